// File: ccd_exec.sv
// execution control for clear, invert, decrement, compare, decimal and watchdog ops
`timescale 1ns/1ps
`include "ccd_consts.svh"
// How it works
// - clear working register, set zero flag
// - clear addressed file register, set zero
// - complement file register to chosen destination
// - decrement file register to chosen destination
// - kick clears watchdog, prescaler if assigned
// - kick sets timeout and sleep flags
// - compare subtracts, keeps both operands unchanged
// - decimal adjust rewrites working register, carry
// - interrupt off clears, on sets enable
module ccd_exec
	import ccd_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic OP_VALID,
	input wire ccd_op_type OP_CODE,
	input wire logic [`CCD_ADDR_W-1:0] FILE_ADDR,
	input wire logic DEST_BIT,
	input wire logic [`CCD_DATA_W-1:0] FILE_RDATA,
	input wire logic ADD_CARRY,
	input wire logic ADD_HALF_CARRY,
	input wire logic PRESCALER_TO_WDOG,
	output logic [`CCD_DATA_W-1:0] WORK_REG,
	output logic ZERO_FLAG,
	output logic CARRY_FLAG,
	output logic FILE_WE,
	output logic [`CCD_ADDR_W-1:0] FILE_WADDR,
	output logic [`CCD_DATA_W-1:0] FILE_WDATA,
	output logic WDOG_CLEAR,
	output logic PRESCALER_CLEAR,
	output logic TIMEOUT_FLAG,
	output logic SLEEP_FLAG,
	output logic IRQ_ENABLE
);
	// ****************************************
	// state and next-state signals
	// ****************************************
	logic [`CCD_DATA_W-1:0] work_q;
	logic [`CCD_DATA_W-1:0] work_d;
	logic zero_q;
	logic zero_d;
	logic carry_q;
	logic carry_d;
	logic fwe_q;
	logic fwe_d;
	logic [`CCD_ADDR_W-1:0] fwaddr_q;
	logic [`CCD_ADDR_W-1:0] fwaddr_d;
	logic [`CCD_DATA_W-1:0] fwdata_q;
	logic [`CCD_DATA_W-1:0] fwdata_d;
	logic wdog_q;
	logic wdog_d;
	logic presc_q;
	logic presc_d;
	logic to_q;
	logic to_d;
	logic pd_q;
	logic pd_d;
	logic irq_q;
	logic irq_d;
	ccd_op_type op_eff;

	// ****************************************
	// arithmetic unit
	// ****************************************
	ccd_alu_if alu_bus();
	ccd_alu u_alu (
		.bus(alu_bus.unit)
	);

	assign op_eff = OP_VALID ? OP_CODE : CCD_OP_NONE;
	assign alu_bus.op = op_eff;
	assign alu_bus.file_val = FILE_RDATA;
	assign alu_bus.work_val = work_q;
	// carry here holds the addition carry only right after an addition
	assign alu_bus.carry_in = ADD_CARRY;
	assign alu_bus.half_in = ADD_HALF_CARRY;

	// ****************************************
	// destination decode
	// ****************************************

	wire routed_op = (op_eff == CCD_OP_INVERT) || (op_eff == CCD_OP_MINUS_ONE);
	wire to_work = (op_eff == CCD_OP_ZERO_WORK) || (op_eff == CCD_OP_DECIMAL_ADJUST)
		|| (routed_op && (DEST_BIT == `CCD_DEST_WORK));
	wire to_file = (op_eff == CCD_OP_ZERO_FILE)
		|| (routed_op && (DEST_BIT != `CCD_DEST_WORK));
	wire kick = (op_eff == CCD_OP_WATCHDOG_KICK);

	assign work_d = to_work ? alu_bus.result : work_q;
	assign zero_d = alu_bus.zero_upd ? alu_bus.zero_val : zero_q;
	assign carry_d = alu_bus.carry_upd ? alu_bus.carry_val : carry_q;

	// ****************************************
	// next-state selection
	// ****************************************
	wire irq_off = (op_eff == CCD_OP_IRQ_OFF);
	wire irq_on = (op_eff == CCD_OP_IRQ_ON);
	// address and data follow every cycle; only the strobe qualifies them
	assign fwe_d = to_file;
	assign fwaddr_d = FILE_ADDR;
	assign fwdata_d = alu_bus.result;
	assign wdog_d = kick;
	// prescaler left alone while the timer owns it
	assign presc_d = kick && PRESCALER_TO_WDOG;
	// only set here; reset also loads them set, so nothing in the group clears them
	assign to_d = kick ? 1'b1 : to_q;
	assign pd_d = kick ? 1'b1 : pd_q;
	assign irq_d = irq_on ? 1'b1
		: irq_off ? 1'b0
		: irq_q;

	// ****************************************
	// working register and status flags
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			work_q <= `CCD_RST_WORK;
		end else begin
			work_q <= work_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			zero_q <= `CCD_RST_ZERO;
		end else begin
			zero_q <= zero_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			carry_q <= `CCD_RST_CARRY;
		end else begin
			carry_q <= carry_d;
		end
	end

	// ****************************************
	// file write port, one-cycle strobe
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			fwe_q <= `CCD_RST_PULSE;
		end else begin
			fwe_q <= fwe_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			fwaddr_q <= `CCD_RST_ADDR;
		end else begin
			fwaddr_q <= fwaddr_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			fwdata_q <= `CCD_ZERO_BYTE;
		end else begin
			fwdata_q <= fwdata_d;
		end
	end

	// ****************************************
	// watchdog restart and power status
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			wdog_q <= `CCD_RST_PULSE;
		end else begin
			wdog_q <= wdog_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			presc_q <= `CCD_RST_PULSE;
		end else begin
			presc_q <= presc_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			to_q <= `CCD_RST_TIMEOUT;
		end else begin
			to_q <= to_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			pd_q <= `CCD_RST_SLEEP;
		end else begin
			pd_q <= pd_d;
		end
	end

	// ****************************************
	// interrupt gate, shared with the add/adjust sequence of software
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			irq_q <= `CCD_RST_IRQ_EN;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign WORK_REG = work_q;
	assign ZERO_FLAG = zero_q;
	assign CARRY_FLAG = carry_q;
	assign FILE_WE = fwe_q;
	assign FILE_WADDR = fwaddr_q;
	assign FILE_WDATA = fwdata_q;
	assign WDOG_CLEAR = wdog_q;
	assign PRESCALER_CLEAR = presc_q;
	assign TIMEOUT_FLAG = to_q;
	assign SLEEP_FLAG = pd_q;
	assign IRQ_ENABLE = irq_q;
endmodule

// File: ccd_consts.svh
// named constants for the clear, compare and decimal execution group
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH
`define CCD_DATA_W 8
`define CCD_ADDR_W 6
`define CCD_ZERO_BYTE 8'h00
`define CCD_ONE_BYTE 8'h01
`define CCD_ALL_ONES 8'hFF
`define CCD_NIB_LIMIT 4'h9
`define CCD_BCD_LIMIT 8'h99
`define CCD_LOW_FIX 8'h06
`define CCD_HIGH_FIX 8'h60
`define CCD_DEST_WORK 1'b0
`define CCD_RST_WORK 8'h00
`define CCD_RST_ZERO 1'b0
`define CCD_RST_CARRY 1'b0
`define CCD_RST_TIMEOUT 1'b1
`define CCD_RST_SLEEP 1'b1
`define CCD_RST_IRQ_EN 1'b0
`define CCD_RST_PULSE 1'b0
`define CCD_RST_ADDR 6'h00
`endif

// File: ccd_pkg.sv
// shared types for the clear, compare and decimal execution group
package ccd_pkg;
	typedef enum logic [3:0] {
		CCD_OP_NONE,
		CCD_OP_ZERO_WORK,
		CCD_OP_ZERO_FILE,
		CCD_OP_INVERT,
		CCD_OP_MINUS_ONE,
		CCD_OP_WATCHDOG_KICK,
		CCD_OP_COMPARE,
		CCD_OP_DECIMAL_ADJUST,
		CCD_OP_IRQ_OFF,
		CCD_OP_IRQ_ON
	} ccd_op_type;
endpackage

// File: ccd_alu_if.sv
// carrier between the execution control and its arithmetic unit
`timescale 1ns/1ps
interface ccd_alu_if;
	import ccd_pkg::*;
	ccd_op_type op;
	logic [7:0] file_val;
	logic [7:0] work_val;
	logic carry_in;
	logic half_in;
	logic [7:0] result;
	logic zero_upd;
	logic zero_val;
	logic carry_upd;
	logic carry_val;
	modport ctrl (output op, output file_val, output work_val, output carry_in,
		output half_in, input result, input zero_upd, input zero_val,
		input carry_upd, input carry_val);
	modport unit (input op, input file_val, input work_val, input carry_in,
		input half_in, output result, output zero_upd, output zero_val,
		output carry_upd, output carry_val);
endinterface

// File: ccd_alu.sv
// arithmetic unit: result and flag values for each operation
`timescale 1ns/1ps
`include "ccd_consts.svh"
module ccd_alu
	import ccd_pkg::*;
(
	ccd_alu_if.unit bus
);
	// ****************************************
	// operation decode
	// ****************************************
	wire is_zw = (bus.op == CCD_OP_ZERO_WORK);
	wire is_zf = (bus.op == CCD_OP_ZERO_FILE);
	wire is_inv = (bus.op == CCD_OP_INVERT);
	wire is_dec = (bus.op == CCD_OP_MINUS_ONE);
	wire is_cmp = (bus.op == CCD_OP_COMPARE);
	wire is_daa = (bus.op == CCD_OP_DECIMAL_ADJUST);

	// ****************************************
	// datapath
	// ****************************************
	wire [7:0] inv_res = bus.file_val ^ `CCD_ALL_ONES;
	wire [7:0] dec_res = bus.file_val - `CCD_ONE_BYTE;
	// ninth bit is the borrow; compare result is never stored
	wire [8:0] cmp_diff = {1'b0, bus.file_val} - {1'b0, bus.work_val};
	// decimal fix relies on the addition flags of the previous cycle
	wire low_fix = (bus.work_val[3:0] > `CCD_NIB_LIMIT) || bus.half_in;
	wire high_fix = (bus.work_val > `CCD_BCD_LIMIT) || bus.carry_in;
	wire [7:0] daa_add = (low_fix ? `CCD_LOW_FIX : `CCD_ZERO_BYTE)
		| (high_fix ? `CCD_HIGH_FIX : `CCD_ZERO_BYTE);
	wire [8:0] daa_sum = {1'b0, bus.work_val} + {1'b0, daa_add};

	assign bus.result = is_inv ? inv_res
		: is_dec ? dec_res
		: is_daa ? daa_sum[7:0]
		: `CCD_ZERO_BYTE;
	assign bus.zero_upd = is_zw | is_zf | is_inv | is_dec | is_cmp;
	assign bus.zero_val = (is_zw | is_zf) ? 1'b1
		: is_cmp ? (cmp_diff[7:0] == `CCD_ZERO_BYTE)
		: (bus.result == `CCD_ZERO_BYTE);
	assign bus.carry_upd = is_cmp | is_daa;
	assign bus.carry_val = is_cmp ? ~cmp_diff[8] : (high_fix | daa_sum[8]);
endmodule

// File: ccd_rf_model.sv
// behavioural register file standing on the decoder side of the group
`timescale 1ns/1ps
module ccd_rf_model (
	input wire logic clk,
	input wire logic [5:0] raddr,
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [64];
	// combinational read, so no forwarding is modelled
	assign rdata = mem[raddr];
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule

// File: ccd_chk_properties.sv
// port assertions for the clear, compare and decimal group
`timescale 1ns/1ps
module ccd_chk
	import ccd_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic OP_VALID,
	input wire ccd_op_type OP_CODE,
	input wire logic DEST_BIT,
	input wire logic [7:0] FILE_RDATA,
	input wire logic PRESCALER_TO_WDOG,
	input wire logic [7:0] WORK_REG,
	input wire logic ZERO_FLAG,
	input wire logic CARRY_FLAG,
	input wire logic FILE_WE,
	input wire logic [7:0] FILE_WDATA,
	input wire logic WDOG_CLEAR,
	input wire logic PRESCALER_CLEAR,
	input wire logic TIMEOUT_FLAG,
	input wire logic SLEEP_FLAG,
	input wire logic IRQ_ENABLE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	ccd_op_type c;
	wire logic [7:0] r = FILE_RDATA;
	wire logic irq_on = OP_CODE == CCD_OP_IRQ_ON;
	assign c = OP_VALID ? OP_CODE : CCD_OP_NONE;
	a_clear_work: assert property (c == CCD_OP_ZERO_WORK |=> WORK_REG == 8'h00 && ZERO_FLAG)
		else $error("clear work wrong");
	a_clear_file: assert property (c == CCD_OP_ZERO_FILE
		|=> FILE_WE && !FILE_WDATA && ZERO_FLAG) else $error("clear file wrong");
	a_invert_file: assert property (c == CCD_OP_INVERT && DEST_BIT |=> FILE_WDATA == ~$past(r)
		&& FILE_WE && $stable(CARRY_FLAG)) else $error("invert wrong");
	a_dec_work: assert property (c == CCD_OP_MINUS_ONE && !DEST_BIT
		|=> WORK_REG == $past(r) - 8'h01 && ZERO_FLAG == !WORK_REG) else $error("decrement wrong");
	a_kick_pulses: assert property (c == CCD_OP_WATCHDOG_KICK |=> WDOG_CLEAR
		&& PRESCALER_CLEAR == $past(PRESCALER_TO_WDOG)) else $error("kick pulses wrong");
	a_kick_flags: assert property (c == CCD_OP_WATCHDOG_KICK |=> TIMEOUT_FLAG && SLEEP_FLAG)
		else $error("kick flags wrong");
	a_kick_single: assert property (WDOG_CLEAR |-> $past(c) == CCD_OP_WATCHDOG_KICK)
		else $error("watchdog clear without kick");
	a_cmp_keep: assert property (c == CCD_OP_COMPARE |=> $stable(WORK_REG) && !FILE_WE)
		else $error("compare changed operand");
	a_cmp_carry: assert property (c == CCD_OP_COMPARE
		|=> CARRY_FLAG == ($past(r) >= $past(WORK_REG))) else $error("compare carry wrong");
	a_adjust_zero: assert property (c == CCD_OP_DECIMAL_ADJUST |=> $stable(ZERO_FLAG) && !FILE_WE)
		else $error("adjust touched zero");
	a_irq_level: assert property (c == CCD_OP_IRQ_OFF || c == CCD_OP_IRQ_ON
		|=> IRQ_ENABLE == $past(irq_on)) else $error("irq enable wrong");
	c_invert: cover property (c == CCD_OP_INVERT);
	c_kick: cover property (c == CCD_OP_WATCHDOG_KICK && PRESCALER_TO_WDOG);
	c_adjust: cover property (c == CCD_OP_DECIMAL_ADJUST);
endmodule
bind ccd_exec ccd_chk i_ccd_chk (
	.REF_CLK(REF_CLK),
	.RESET_N(RESET_N),
	.OP_VALID(OP_VALID),
	.OP_CODE(OP_CODE),
	.DEST_BIT(DEST_BIT),
	.FILE_RDATA(FILE_RDATA),
	.PRESCALER_TO_WDOG(PRESCALER_TO_WDOG),
	.WORK_REG(WORK_REG),
	.ZERO_FLAG(ZERO_FLAG),
	.CARRY_FLAG(CARRY_FLAG),
	.FILE_WE(FILE_WE),
	.FILE_WDATA(FILE_WDATA),
	.WDOG_CLEAR(WDOG_CLEAR),
	.PRESCALER_CLEAR(PRESCALER_CLEAR),
	.TIMEOUT_FLAG(TIMEOUT_FLAG),
	.SLEEP_FLAG(SLEEP_FLAG),
	.IRQ_ENABLE(IRQ_ENABLE)
);

// File: tb_top.sv
// self-checking bench for the clear, compare and decimal group
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top import ccd_pkg::*;;
	logic REF_CLK = 1'h0;
	logic RESET_N = 1'h0;
	logic OP_VALID = 1'h0;
	ccd_op_type OP_CODE = CCD_OP_NONE;
	logic [5:0] FILE_ADDR = 6'h00;
	logic DEST_BIT = 1'h0;
	logic ADD_CARRY = 1'h0;
	logic ADD_HALF_CARRY = 1'h0;
	logic PRESCALER_TO_WDOG = 1'h0;
	wire logic [7:0] FILE_RDATA, WORK_REG, FILE_WDATA;
	wire logic [5:0] FILE_WADDR;
	wire logic ZERO_FLAG, CARRY_FLAG, FILE_WE, WDOG_CLEAR, PRESCALER_CLEAR;
	wire logic TIMEOUT_FLAG, SLEEP_FLAG, IRQ_ENABLE;
	int mismatches = 0;
	int cmp_count = 0;
	ccd_exec i_ccd_exec (
		.REF_CLK(REF_CLK),
		.RESET_N(RESET_N),
		.OP_VALID(OP_VALID),
		.OP_CODE(OP_CODE),
		.FILE_ADDR(FILE_ADDR),
		.DEST_BIT(DEST_BIT),
		.FILE_RDATA(FILE_RDATA),
		.ADD_CARRY(ADD_CARRY),
		.ADD_HALF_CARRY(ADD_HALF_CARRY),
		.PRESCALER_TO_WDOG(PRESCALER_TO_WDOG),
		.WORK_REG(WORK_REG),
		.ZERO_FLAG(ZERO_FLAG),
		.CARRY_FLAG(CARRY_FLAG),
		.FILE_WE(FILE_WE),
		.FILE_WADDR(FILE_WADDR),
		.FILE_WDATA(FILE_WDATA),
		.WDOG_CLEAR(WDOG_CLEAR),
		.PRESCALER_CLEAR(PRESCALER_CLEAR),
		.TIMEOUT_FLAG(TIMEOUT_FLAG),
		.SLEEP_FLAG(SLEEP_FLAG),
		.IRQ_ENABLE(IRQ_ENABLE)
	);
	ccd_rf_model i_ccd_rf_model (.clk(REF_CLK), .raddr(FILE_ADDR), .we(FILE_WE),
		.waddr(FILE_WADDR), .wdata(FILE_WDATA), .rdata(FILE_RDATA));
	initial begin
		forever #2 REF_CLK = ~REF_CLK;
	end
	// one op per call; outputs are looked at just after their edge
	task automatic op(input ccd_op_type c, input logic [5:0] a, input logic d, input logic [7:0] r);
		i_ccd_rf_model.mem[a] = r;
		@(posedge REF_CLK);
		OP_VALID <= 1'h1;
		OP_CODE <= c;
		FILE_ADDR <= a;
		DEST_BIT <= d;
		@(posedge REF_CLK);
		OP_VALID <= 1'h0;
		#1;
	endtask
	task automatic t_invert_dec();
		op(CCD_OP_INVERT, 6'h05, 1'h1, 8'ha6);
		`CHK({FILE_WE, FILE_WADDR, FILE_WDATA, ZERO_FLAG}, {1'h1, 6'h05, 8'h59, 1'h0})
		op(CCD_OP_MINUS_ONE, 6'h2a, 1'h0, 8'h01);
		`CHK({WORK_REG, ZERO_FLAG, FILE_WE}, {8'h00, 1'h1, 1'h0})
		op(CCD_OP_MINUS_ONE, 6'h3f, 1'h1, 8'h00);
		`CHK({FILE_WE, FILE_WADDR, FILE_WDATA, ZERO_FLAG}, {1'h1, 6'h3f, 8'hff, 1'h0})
	endtask
	task automatic t_clear();
		op(CCD_OP_ZERO_FILE, 6'h3f, 1'h0, 8'h55);
		`CHK({FILE_WE, FILE_WADDR, FILE_WDATA, ZERO_FLAG}, {1'h1, 6'h3f, 8'h00, 1'h1})
		op(CCD_OP_INVERT, 6'h00, 1'h0, 8'haa);
		op(CCD_OP_ZERO_WORK, 6'h00, 1'h0, 8'h55);
		`CHK({WORK_REG, ZERO_FLAG}, {8'h00, 1'h1})
	endtask
	task automatic t_kick(input logic p);
		@(posedge REF_CLK);
		PRESCALER_TO_WDOG <= p;
		op(CCD_OP_WATCHDOG_KICK, 6'h00, 1'h0, 8'h00);
		`CHK({WDOG_CLEAR, PRESCALER_CLEAR}, {1'h1, p})
		`CHK({TIMEOUT_FLAG, SLEEP_FLAG}, 2'h3)
	endtask
	task automatic t_cmp(input logic [7:0] r, input logic [1:0] zc);
		op(CCD_OP_INVERT, 6'h00, 1'h0, 8'hed);
		op(CCD_OP_COMPARE, 6'h07, 1'h0, r);
		`CHK({ZERO_FLAG, CARRY_FLAG, WORK_REG, FILE_WE}, {zc, 8'h12, 1'h0})
	endtask
	task automatic t_adjust(input logic [7:0] sum_n, input logic cy, input logic [8:0] exp);
		op(CCD_OP_IRQ_OFF, 6'h00, 1'h0, 8'h00);
		`CHK(IRQ_ENABLE, 1'h0)
		op(CCD_OP_INVERT, 6'h00, 1'h0, sum_n);
		@(posedge REF_CLK);
		ADD_CARRY <= cy;
		ADD_HALF_CARRY <= cy;
		op(CCD_OP_DECIMAL_ADJUST, 6'h00, 1'h0, 8'h00);
		`CHK({CARRY_FLAG, WORK_REG, ZERO_FLAG}, {exp, 1'h0})
		op(CCD_OP_IRQ_ON, 6'h00, 1'h0, 8'h00);
		`CHK(IRQ_ENABLE, 1'h1)
	endtask
	task automatic conclude();
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge REF_CLK);
		RESET_N <= 1'h1;
		t_invert_dec();
		t_clear();
		t_kick(1'h0);
		t_kick(1'h1);
		t_cmp(8'h34, 2'h1);
		t_cmp(8'h12, 2'h3);
		t_cmp(8'h11, 2'h0);
		t_adjust(8'hb2, 1'h0, 9'h053);
		t_adjust(8'hcd, 1'h1, 9'h198);
		conclude();
	end
endmodule
